// ==== hw/scp_pkg.sv ====
// shared constants, types and helpers for the serial command port
package scp_pkg;
  // command byte layout and codes
  localparam int             CMD_LEN_BITS  = 8;
  localparam int             CMD_NWE_POS   = 7;
  localparam int             CMD_RW_HI     = 5;
  localparam int             CMD_RW_LO     = 4;
  localparam int             CMD_ADDR_HI   = 2;
  localparam logic [7:0]     CMD_WR_MODE   = 8'h02;
  localparam logic [7:0]     CMD_CONT_RD   = 8'h21;
  localparam logic [7:0]     CMD_EXIT_CONT = 8'h30;
  localparam logic [1:0]     RW_WRITE      = 2'h0;
  localparam logic [1:0]     RW_READ       = 2'h1;
  localparam logic [1:0]     RW_CONT       = 2'h2;
  localparam logic [15:0]    MODE_CONT_CONV = 16'h2180;
  // device register addresses and lengths
  localparam logic [2:0]     REG_STATUS    = 3'h0;
  localparam logic [2:0]     REG_DATA      = 3'h1;
  localparam logic [2:0]     REG_MODE      = 3'h2;
  localparam logic [2:0]     REG_DAC       = 3'h4;
  localparam logic [4:0]     LEN_BYTE      = 5'h08;
  localparam logic [4:0]     LEN_HALF      = 5'h10;
  localparam logic [4:0]     LEN_WORD      = 5'h18;
  localparam int             WORD_W        = 24;
  localparam int             READY_POS     = 7;
  // host command port map (word index) and fields
  localparam logic [2:0]     HA_TX         = 3'h0;
  localparam logic [2:0]     HA_CTRL       = 3'h1;
  localparam logic [2:0]     HA_STAT       = 3'h2;
  localparam logic [2:0]     HA_RX         = 3'h3;
  localparam logic [2:0]     HA_CFG        = 3'h4;
  localparam int             CTRL_BYTES_HI = 1;
  localparam int             CTRL_READ_POS = 2;
  localparam int             CFG_POL_POS   = 0;
  localparam int             STAT_BUSY_POS = 0;
  localparam int             STAT_RDY_POS  = 1;
  // serial clock made by the host
  localparam int             CLK_PERIOD_NS  = 25;
  localparam int             SCLK_PERIOD_NS = 400;
  localparam int             SCLK_HALF_CYC  = (SCLK_PERIOD_NS / 2) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {PH_CMD, PH_WRITE, PH_READ, PH_CONT} dev_phase_t;
  typedef enum logic [2:0] {H_IDLE, H_SETUP, H_LEAD, H_TRAIL, H_HOLD} host_state_t;

  // bit length of a device register
  function automatic logic [4:0] reg_len(input logic [2:0] a);
    case (a)
      REG_STATUS, REG_DAC: reg_len = LEN_BYTE;
      REG_MODE:            reg_len = LEN_HALF;
      default:             reg_len = LEN_WORD;
    endcase
  endfunction

  // move an n-bit value to the top of a word for msb-first shifting
  function automatic logic [23:0] align_top(input logic [23:0] v, input logic [4:0] n);
    align_top = v << (LEN_WORD - n);
  endfunction
endpackage

// ==== hw/scp_if.sv ====
// serial link between converter port and its host
`timescale 1ns/1ps
interface scp_if;
  logic sclk;
  logic cs_n;
  logic din;
  logic dout;
  logic dout_oe;
  logic rdy_n;
  logic clock_polarity_select;

  modport dev (
    input  sclk, cs_n, din, clock_polarity_select,
    output dout, dout_oe, rdy_n
  );
  modport host (
    output sclk, cs_n, din, clock_polarity_select,
    input  dout, rdy_n
  );
endinterface

// ==== hw/scp_device.sv ====
// converter serial command port, device end
// Functional notes
// [R01] command 02 hex selects mode register write
// [R02] mode value 2180 hex starts continuous conversion
// [R03] command 21 hex enters continuous data read
// [R04] host holds data input low in continuous read
// [R05] ready goes low on new result
// [R06] host reads whole 24-bit result after ready
// [R07] command 30 hex leaves continuous read
// [R08] registers are 8, 16 or 24 bits
// [R09] after any write, expect a command
// [R10] trailing all-ones command byte is ignored
// [R11] register write follows command without gap
// [R12] no output data during writes
// [R13] input still sampled during continuous read
// [R14] polarity select matches host clock idle level
// [R15] most significant bit first both ways
// [R16] status register ready bit mirrors ready (code drives the bit as the inverse of rdy_n, 1 while ready is low)
// [R17] works with chip select held low
// [R18] shared data wire forbids continuous read
// [R19] free-running clock needs chip select framing
// [R20] dsp host clock at most 3 MHz
// [R21] output shifts on falling edge if polarity high
// [R22] ready high after data read, before update
// [R23] input captured on rising edge if polarity high
// [R24] chip select release restarts word
`timescale 1ns/1ps
module scp_device (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // serial link
  scp_if.dev               link,
  // converter side
  input  wire logic [23:0] result_data,
  input  wire logic        result_valid,
  output logic      [15:0] mode_word,
  output logic             conv_run
);
  // synchronisers and edge finding
  logic [2:0]  sclk_q;
  logic [1:0]  cs_q;
  logic [1:0]  din_q;
  logic [1:0]  pol_q;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        cap_edge;
  logic        launch_edge;
  logic        active;
  // serial engine
  scp_pkg::dev_phase_t phase_r;
  logic [2:0]  addr_r;
  logic [4:0]  len_r;
  logic [4:0]  cnt_r;
  logic [23:0] sh_in_r;
  logic [23:0] sh_out_r;
  logic        dout_r;
  logic        oe_r;
  // registers and ready
  logic [23:0] regs_r [0:7];
  logic [23:0] data_r;
  logic [23:0] hold_r;
  logic        upd_r;
  logic        rdy_n_r;
  logic [15:0] mode_r;
  logic        run_r;
  // decode helpers
  logic [23:0] in_word;
  logic        last_bit;
  logic        cmd_done;
  logic        wr_done;
  logic        data_rd_done;
  logic [2:0]  cmd_addr;
  logic [1:0]  cmd_rw;
  logic [23:0] rd_val;

  // two flops on every pin, third flop only for sclk edges
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sclk_q <= 3'h0;
      cs_q   <= 2'h3;
      din_q  <= 2'h0;
      pol_q  <= 2'h0;
    end else begin
      sclk_q <= {sclk_q[1:0], link.sclk};
      cs_q   <= {cs_q[0], link.cs_n};
      din_q  <= {din_q[0], link.din};
      pol_q  <= {pol_q[0], link.clock_polarity_select};
    end
  end

  assign sclk_rise   = sclk_q[1] & ~sclk_q[2];
  assign sclk_fall   = ~sclk_q[1] & sclk_q[2];
  assign cap_edge    = pol_q[1] ? sclk_rise : sclk_fall;  // [R23]
  assign launch_edge = pol_q[1] ? sclk_fall : sclk_rise;  // [R21]
  assign active      = ~cs_q[1];                          // [R17]

  // incoming word, msb first, and word boundaries
  assign in_word  = {sh_in_r[22:0], din_q[1]};            // [R15]
  assign cmd_addr = in_word[scp_pkg::CMD_ADDR_HI:0];
  assign cmd_rw   = in_word[scp_pkg::CMD_RW_HI:scp_pkg::CMD_RW_LO];
  assign last_bit = (cnt_r == len_r - 5'h01);
  assign cmd_done = active && cap_edge && phase_r == scp_pkg::PH_CMD
                    && cnt_r == 5'(scp_pkg::CMD_LEN_BITS - 1)
                    && !in_word[scp_pkg::CMD_NWE_POS];     // [R10]
  assign wr_done  = active && cap_edge && phase_r == scp_pkg::PH_WRITE && last_bit;
  assign data_rd_done = active && cap_edge && last_bit
                    && (phase_r == scp_pkg::PH_CONT
                        || (phase_r == scp_pkg::PH_READ && addr_r == scp_pkg::REG_DATA));

  // value parallel-loaded into the output shifter
  always_comb begin
    rd_val = regs_r[cmd_addr];
    if (phase_r == scp_pkg::PH_CONT || cmd_addr == scp_pkg::REG_DATA) begin
      rd_val = data_r;
    end else if (cmd_addr == scp_pkg::REG_STATUS) begin
      rd_val = 24'h000000;
      rd_val[scp_pkg::READY_POS] = ~rdy_n_r;               // [R16]
    end
  end

  // command sequencing and bit counting
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      phase_r <= scp_pkg::PH_CMD;
      addr_r  <= scp_pkg::REG_STATUS;
      len_r   <= scp_pkg::LEN_BYTE;
      cnt_r   <= 5'h00;
      sh_in_r <= 24'h000000;
    end else if (!active) begin
      cnt_r <= 5'h00;                                      // [R24]
    end else if (cap_edge) begin
      sh_in_r <= in_word;
      cnt_r   <= cnt_r + 5'h01;
      case (phase_r)
        scp_pkg::PH_CMD: begin
          if (cnt_r == 5'(scp_pkg::CMD_LEN_BITS - 1)) begin
            cnt_r <= 5'h00;                                // [R11]
            if (cmd_done) begin
              addr_r <= cmd_addr;
              len_r  <= scp_pkg::reg_len(cmd_addr);        // [R08]
              case (cmd_rw)
                scp_pkg::RW_WRITE: phase_r <= scp_pkg::PH_WRITE; // [R01]
                scp_pkg::RW_READ:  phase_r <= scp_pkg::PH_READ;
                scp_pkg::RW_CONT: begin
                  if (cmd_addr == scp_pkg::REG_DATA) begin
                    phase_r <= scp_pkg::PH_CONT;           // [R03]
                  end
                end
                default: phase_r <= scp_pkg::PH_CMD;
              endcase
            end
          end
        end
        scp_pkg::PH_WRITE, scp_pkg::PH_READ: begin
          if (last_bit) begin
            cnt_r   <= 5'h00;
            phase_r <= scp_pkg::PH_CMD;                    // [R09]
          end
        end
        scp_pkg::PH_CONT: begin
          // watch every byte for the exit command
          if (cnt_r[2:0] == 3'h7 && in_word[7:0] == scp_pkg::CMD_EXIT_CONT) begin
            cnt_r   <= 5'h00;                              // [R13]
            phase_r <= scp_pkg::PH_CMD;                    // [R07]
          end else if (last_bit) begin
            cnt_r <= 5'h00;
          end
        end
        default: phase_r <= scp_pkg::PH_CMD;
      endcase
    end
  end

  // register writes and mode decode
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 8; i++) begin
        regs_r[i] <= 24'h000000;
      end
      mode_r <= 16'h0000;
      run_r  <= 1'b0;
    end else if (wr_done) begin
      regs_r[addr_r] <= in_word;
      if (addr_r == scp_pkg::REG_MODE) begin
        mode_r <= in_word[15:0];
        run_r  <= (in_word[15:0] == scp_pkg::MODE_CONT_CONV); // [R02]
      end
    end
  end

  // output shifter: drives only while reading
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sh_out_r <= 24'h000000;
      dout_r   <= 1'b0;
      oe_r     <= 1'b0;
    end else if (!active) begin
      oe_r <= 1'b0;
      // between framed words the next continuous read must see the newest result
      if (phase_r == scp_pkg::PH_CONT) begin
        sh_out_r <= data_r;                                // [R03]
      end
    end else if (cmd_done && (cmd_rw == scp_pkg::RW_READ || cmd_rw == scp_pkg::RW_CONT)) begin
      sh_out_r <= scp_pkg::align_top(rd_val, scp_pkg::reg_len(cmd_addr));
    end else if (phase_r == scp_pkg::PH_CONT && cap_edge && last_bit) begin
      sh_out_r <= data_r;                                  // [R03]
    end else if (launch_edge) begin
      if (phase_r == scp_pkg::PH_READ || phase_r == scp_pkg::PH_CONT) begin
        dout_r   <= sh_out_r[23];                          // [R15]
        sh_out_r <= {sh_out_r[22:0], 1'b0};
        oe_r     <= 1'b1;
      end else begin
        oe_r <= 1'b0;                                      // [R12]
      end
    end
  end

  // data register update and ready flag
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      data_r  <= 24'h000000;
      hold_r  <= 24'h000000;
      upd_r   <= 1'b0;
      rdy_n_r <= 1'b1;
    end else if (result_valid) begin
      hold_r  <= result_data;
      upd_r   <= 1'b1;
      rdy_n_r <= 1'b1;                                     // [R22]
    end else if (upd_r) begin
      data_r  <= hold_r;
      upd_r   <= 1'b0;
      rdy_n_r <= 1'b0;                                     // [R05]
    end else if (data_rd_done) begin
      rdy_n_r <= 1'b1;                                     // [R22]
    end
  end

  assign link.dout    = dout_r;
  assign link.dout_oe = oe_r;
  assign link.rdy_n   = rdy_n_r;
  assign mode_word    = mode_r;
  assign conv_run     = run_r;
endmodule

// ==== hw/scp_host.sv ====
// serial port host end driving the converter link
`timescale 1ns/1ps
module scp_host (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // serial link
  scp_if.host              link,
  // software command port
  input  wire logic [2:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata
);
  localparam logic [3:0] HALF_LAST = 4'(scp_pkg::SCLK_HALF_CYC - 1);  // sclk well under 3 MHz [R20]

  scp_pkg::host_state_t st_r;
  logic [3:0]  div_r;
  logic        tick;
  logic [23:0] tx_r;
  logic [23:0] sh_r;
  logic [23:0] rx_r;
  logic [4:0]  bits_r;
  logic        rd_mode_r;
  logic        pol_r;
  logic        sclk_r;
  logic        cs_n_r;
  logic        din_r;
  logic [1:0]  dout_q;
  logic [1:0]  rdy_q;
  logic [31:0] rdata_r;
  logic        start;

  assign tick  = (div_r == HALF_LAST);
  assign start = wr && addr == scp_pkg::HA_CTRL && st_r == scp_pkg::H_IDLE
                 && wdata[scp_pkg::CTRL_BYTES_HI:0] != 2'h0;

  // pin inputs pass two flops
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dout_q <= 2'h0;
      rdy_q  <= 2'h3;
    end else begin
      dout_q <= {dout_q[0], link.dout};
      rdy_q  <= {rdy_q[0], link.rdy_n};
    end
  end

  // half-period divider for the serial clock
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      div_r <= 4'h0;
    end else if (st_r == scp_pkg::H_IDLE || tick) begin
      div_r <= 4'h0;
    end else begin
      div_r <= div_r + 4'h1;
    end
  end

  // software registers: data word and polarity
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx_r  <= 24'h000000;
      pol_r <= 1'b0;
    end else if (wr && st_r == scp_pkg::H_IDLE) begin
      if (addr == scp_pkg::HA_TX) begin
        tx_r <= wdata[23:0];
      end
      if (addr == scp_pkg::HA_CFG) begin
        pol_r <= wdata[scp_pkg::CFG_POL_POS];              // [R14]
      end
    end
  end

  // transfer sequencer, one framed word per start
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_r      <= scp_pkg::H_IDLE;
      sh_r      <= 24'h000000;
      rx_r      <= 24'h000000;
      bits_r    <= 5'h00;
      rd_mode_r <= 1'b0;
      sclk_r    <= 1'b0;
      cs_n_r    <= 1'b1;
      din_r     <= 1'b0;
    end else begin
      case (st_r)
        scp_pkg::H_IDLE: begin
          sclk_r <= pol_r;                                 // [R14]
          if (start) begin
            bits_r    <= {wdata[scp_pkg::CTRL_BYTES_HI:0], 3'h0};
            sh_r      <= scp_pkg::align_top(tx_r, {wdata[scp_pkg::CTRL_BYTES_HI:0], 3'h0});
            rd_mode_r <= wdata[scp_pkg::CTRL_READ_POS];
            cs_n_r    <= 1'b0;
            st_r      <= scp_pkg::H_SETUP;
          end
        end
        scp_pkg::H_SETUP, scp_pkg::H_TRAIL: begin
          if (tick) begin
            sclk_r <= ~pol_r;
            din_r  <= rd_mode_r ? 1'b0 : sh_r[23];         // [R04]
            sh_r   <= {sh_r[22:0], 1'b0};                  // [R15]
            st_r   <= scp_pkg::H_LEAD;
          end
        end
        scp_pkg::H_LEAD: begin
          if (tick) begin
            sclk_r <= pol_r;
            rx_r   <= {rx_r[22:0], dout_q[1]};
            bits_r <= bits_r - 5'h01;
            st_r   <= (bits_r == 5'h01) ? scp_pkg::H_HOLD : scp_pkg::H_TRAIL;
          end
        end
        scp_pkg::H_HOLD: begin
          if (tick) begin
            cs_n_r <= 1'b1;                                // [R19]
            din_r  <= 1'b0;
            st_r   <= scp_pkg::H_IDLE;
          end
        end
        default: st_r <= scp_pkg::H_IDLE;
      endcase
    end
  end

  // read data one cycle after the strobe
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata_r <= 32'h00000000;
    end else if (rd) begin
      rdata_r <= 32'h00000000;
      case (addr)
        scp_pkg::HA_TX:   rdata_r[23:0] <= tx_r;
        scp_pkg::HA_RX:   rdata_r[23:0] <= rx_r;
        scp_pkg::HA_CFG:  rdata_r[scp_pkg::CFG_POL_POS] <= pol_r;
        scp_pkg::HA_STAT: begin
          rdata_r[scp_pkg::STAT_BUSY_POS] <= (st_r != scp_pkg::H_IDLE);
          rdata_r[scp_pkg::STAT_RDY_POS]  <= ~rdy_q[1];
        end
        default: rdata_r <= 32'h00000000;
      endcase
    end
  end

  assign link.sclk                  = sclk_r;
  assign link.cs_n                  = cs_n_r;
  assign link.din                   = din_r;  // own wire, never shared with dout [R18]
  assign link.clock_polarity_select = pol_r;
  assign rdata                      = rdata_r;
endmodule

// ==== verif/scp_link_assertions.sv ====
// concurrent checks on the serial link between host and device
`timescale 1ns/1ps
module scp_link_assertions (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  input wire logic dout,
  input wire logic dout_oe,
  input wire logic rdy_n,
  input wire logic clock_polarity_select
);
  logic [5:0] bits_r;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // capture edges seen inside the current frame
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bits_r <= 6'h00;
    end else if (cs_n) begin
      bits_r <= 6'h00;
    end else if ($changed(sclk) && sclk == clock_polarity_select) begin
      bits_r <= bits_r + 6'h01;
    end
  end

  // framing, clock shape and data edges
  a_frame_whole_bytes: assert property ($rose(cs_n) |-> bits_r inside {8, 16, 24})
    else $error("frame ended off a byte boundary");
  a_cs_frame_min: assert property ($fell(cs_n) |-> !cs_n [*8])
    else $error("chip select frame too short");
  a_cs_end_idle: assert property ($rose(cs_n) |->
    sclk == clock_polarity_select && $past(sclk, 6) == clock_polarity_select)
    else $error("frame closed with clock away from idle");
  a_sclk_half_len: assert property ($changed(sclk) |=> $stable(sclk) [*7])
    else $error("serial clock half period too short");
  a_clk_idle_level: assert property (cs_n && $stable(clock_polarity_select) &&
    $past(clock_polarity_select, 2) == clock_polarity_select |->
    sclk == clock_polarity_select)
    else $error("serial clock idles at wrong level");
  a_din_capture: assert property (!cs_n && $changed(sclk) &&
    sclk == clock_polarity_select |-> $stable(din))
    else $error("data input moved at its capture edge");
  a_dout_launch: assert property (!cs_n && dout_oe && $changed(dout) |->
    sclk != clock_polarity_select)
    else $error("data output moved after the wrong clock edge");
  a_oe_idle_off: assert property (cs_n [*6] |-> !dout_oe)
    else $error("data output driven outside a frame");
  c_ready_seen: cover property ($fell(rdy_n));
endmodule

// ==== verif/converter_serial_command_port_test.sv ====
// self-checking bench, host and device joined over the serial link
`timescale 1ns/1ps
module converter_serial_command_port_test;
  logic        ref_clk;
  logic        rst;
  logic [2:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic [23:0] result_data;
  logic        result_valid;
  logic [15:0] mode_word;
  logic        conv_run;
  logic [31:0] d;
  logic        oe_seen;
  logic        din_seen;
  logic [23:0] cont_vals [0:1] = '{24'h5A0F3C, 24'hFFFFFE};
  int          err_total;
  int          cmp_count;
  int          cycles;

  scp_if link ();
  scp_device i_scp_device (.ref_clk(ref_clk), .rst(rst), .link(link),
    .result_data(result_data), .result_valid(result_valid),
    .mode_word(mode_word), .conv_run(conv_run));
  scp_host i_scp_host (.ref_clk(ref_clk), .rst(rst), .link(link), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  scp_link_assertions i_scp_link_assertions (.ref_clk(ref_clk), .rst(rst),
    .sclk(link.sclk), .cs_n(link.cs_n), .din(link.din), .dout(link.dout),
    .dout_oe(link.dout_oe), .rdy_n(link.rdy_n),
    .clock_polarity_select(link.clock_polarity_select));

  // 40 MHz clock
  initial ref_clk = 1'b0;
  always #12.5 ref_clk = ~ref_clk;

  // wire watchers and hang guard
  always @(posedge ref_clk) begin
    if (link.dout_oe !== 1'b0) oe_seen = 1'b1;
    if (link.cs_n === 1'b0 && link.din !== 1'b0) din_seen = 1'b1;
    cycles = cycles + 1;
    if (cycles == 30000) begin
      err_total++;
      $display("ERROR cycles expected below 30000 seen 30000");
      summarize();
    end
  end

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic bus_wr(input logic [2:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask

  task automatic bus_rd(input logic [2:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask

  // one framed transfer, received word left in d
  task automatic xfer(input logic [23:0] tx, input logic [1:0] n, input logic rdm);
    int k;
    oe_seen = 1'b0;
    din_seen = 1'b0;
    bus_wr(scp_pkg::HA_TX, {8'h00, tx});
    bus_wr(scp_pkg::HA_CTRL, {29'h0, rdm, n});
    repeat (3) @(posedge ref_clk);
    k = 0;
    d = 32'h1;
    while (d[scp_pkg::STAT_BUSY_POS] !== 1'b0 && k < 500) begin
      bus_rd(scp_pkg::HA_STAT, d);
      k++;
    end
    if (k == 500) begin
      err_total++;
      $display("ERROR busy expected 0 seen 1");
    end
    repeat (6) @(posedge ref_clk);
    bus_rd(scp_pkg::HA_RX, d);
  endtask

  task automatic stat_read();
    xfer(24'h000010, 2'h1, 1'b0);
    xfer(24'h000000, 2'h1, 1'b1);
  endtask

  task automatic put_result(input logic [23:0] v);
    @(posedge ref_clk);
    result_data <= v;
    result_valid <= 1'b1;
    @(posedge ref_clk);
    result_valid <= 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask

  // main sequence
  initial begin
    rst = 1'b1;
    addr = 3'h0;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    result_data = 24'h0;
    result_valid = 1'b0;
    err_total = 0;
    cmp_count = 0;
    cycles = 0;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk("mode_word", 32'h0, {16'h0, mode_word});
    chk("rdy_n", 32'h1, {31'h0, link.rdy_n});
    $display("test reset done");
    xfer({scp_pkg::CMD_WR_MODE, 16'h2180}, 2'h3, 1'b0);
    chk("mode_word", 32'h2180, {16'h0, mode_word});
    chk("conv_run", 32'h1, {31'h0, conv_run});
    chk("dout_oe in write", 32'h0, {31'h0, oe_seen});
    chk("sclk idle", 32'h0, {31'h0, link.sclk});
    $display("test mode write done");
    put_result(24'hA5C3F1);
    chk("rdy_n", 32'h0, {31'h0, link.rdy_n});
    bus_rd(scp_pkg::HA_STAT, d);
    chk("host ready", 32'h1, {31'h0, d[scp_pkg::STAT_RDY_POS]});
    stat_read();
    chk("status", 32'h80, {24'h0, d[7:0]});
    xfer(24'h000011, 2'h1, 1'b0);
    xfer(24'h000000, 2'h3, 1'b1);
    chk("data", 32'hA5C3F1, {8'h0, d[23:0]});
    chk("din in read", 32'h0, {31'h0, din_seen});
    chk("rdy_n", 32'h1, {31'h0, link.rdy_n});
    $display("test single read done");
    xfer(24'h000021, 2'h1, 1'b0);
    for (int i = 0; i < 2; i++) begin
      put_result(cont_vals[i]);
      xfer(24'h000000, 2'h3, 1'b1);
      chk("cont data", {8'h0, cont_vals[i]}, {8'h0, d[23:0]});
      chk("rdy_n", 32'h1, {31'h0, link.rdy_n});
    end
    xfer(24'h000030, 2'h1, 1'b0);
    put_result(24'h123456);
    stat_read();
    chk("status after exit", 32'h80, {24'h0, d[7:0]});
    $display("test continuous read done");
    xfer({scp_pkg::CMD_WR_MODE, 16'h2100}, 2'h3, 1'b0);
    xfer(24'h0000FF, 2'h1, 1'b0);
    stat_read();
    chk("status after ff", 32'h80, {24'h0, d[7:0]});
    chk("mode_word", 32'h2100, {16'h0, mode_word});
    chk("conv_run", 32'h0, {31'h0, conv_run});
    $display("test trailing byte done");
    bus_wr(scp_pkg::HA_CFG, 32'h1);
    repeat (4) @(posedge ref_clk);
    #1;
    chk("sclk idle", 32'h1, {31'h0, link.sclk});
    xfer({scp_pkg::CMD_WR_MODE, 16'h2180}, 2'h3, 1'b0);
    chk("mode_word", 32'h2180, {16'h0, mode_word});
    put_result(24'h3C5A96);
    xfer(24'h000011, 2'h1, 1'b0);
    xfer(24'h000000, 2'h3, 1'b1);
    chk("data", 32'h3C5A96, {8'h0, d[23:0]});
    $display("test high polarity done");
    xfer(24'h000423, 2'h2, 1'b0);
    xfer(24'h000014, 2'h1, 1'b0);
    xfer(24'h000000, 2'h1, 1'b1);
    chk("short reg", 32'h23, {24'h0, d[7:0]});
    xfer(24'h000012, 2'h1, 1'b0);
    xfer(24'h000000, 2'h2, 1'b1);
    chk("mode readback", 32'h2180, {16'h0, d[15:0]});
    $display("test short registers done");
    summarize();
  end
endmodule
